// File: logic/tpc_cfg.svh
// Purpose: Offsets, field positions, reset values and timing constants
// Assumes: 100 MHz reference clock
// Notes: Field positions are given as part-select ranges
`ifndef TPC_CFG_SVH
`define TPC_CFG_SVH
////////////////////////////////////////////////////////////////////////////
`define TPC_OFF_CTL 8'h04
`define TPC_OFF_CTL2 8'h05
`define TPC_OFF_MANUAL 8'h09
`define TPC_OFF_SWRST 8'h0A
`define TPC_OFF_MASK 8'h0E
`define TPC_OFF_MASK2 8'h0F
`define TPC_OFF_FLAGS 8'h14
`define TPC_OFF_FLAGS2 8'h15
////////////////////////////////////////////////////////////////////////////
`define TPC_RST_CTL 8'h4B
`define TPC_RST_CTL2 8'hB3
`define TPC_RST_MASK 8'h00
`define TPC_MASK_USED 8'h7F
`define TPC_MASK2_USED 8'h6F
////////////////////////////////////////////////////////////////////////////
`define TPC_F_PERIOD 7:6
`define TPC_F_SPLIT 5:4
`define TPC_B_DANGLE 3
`define TPC_F_PULLUP 2:1
`define TPC_B_GMASK 0
`define TPC_B_REMEDY 7
`define TPC_F_WEAKTH 6:5
`define TPC_B_WEAKEN 4
`define TPC_B_DETEN 3
`define TPC_F_DEB 2:0
`define TPC_B_FSRC 5
`define TPC_B_FSNK 4
`define TPC_B_USNK 3
`define TPC_B_USRC 2
`define TPC_B_DIS 1
`define TPC_B_ERR 0
`define TPC_B_SWRST 0
`define TPC_B_ORIENT 6
`define TPC_PULLUP_RSV 2'h0
`define TPC_DEB_RSV 3'h7
////////////////////////////////////////////////////////////////////////////
`define TPC_CLK_MHZ 100
`define TPC_PERIOD_BASE_MS 60
`define TPC_PERIOD_STEP_MS 10
`define TPC_SPLIT_BASE_PCT 60
`define TPC_SPLIT_STEP_PCT 10
`define TPC_DEB_BASE_MS 120
`define TPC_DEB_STEP_MS 10
`define TPC_I2C_ADDR 7'h21
`endif

// File: logic/tpc_pkg.sv
// Purpose: Types shared by the port control register bank
// Assumes: Nothing beyond the config header
// Notes: Binary codes written out for every state
package tpc_pkg;
	typedef enum logic [2:0] {
		I2C_IDLE = 3'b000,
		I2C_ADDR = 3'b001,
		I2C_AACK = 3'b010,
		I2C_REG = 3'b011,
		I2C_WACK = 3'b100,
		I2C_WDATA = 3'b101,
		I2C_RDATA = 3'b110,
		I2C_RACK = 3'b111
	} tpc_i2c_st_t;
	typedef enum logic [2:0] {
		CMD_NONE = 3'b000,
		CMD_RECOVER = 3'b001,
		CMD_FORCE_SOURCE_CMD = 3'b010,
		CMD_FORCE_SINK_CMD = 3'b011,
		CMD_GOTO_UNATTACHED_SOURCE_CMD = 3'b100,
		CMD_GOTO_UNATTACHED_SINK_CMD = 3'b101
	} tpc_cmd_t;
	typedef enum logic [1:0] {
		ROLE_DUAL = 2'b00,
		ROLE_SINK = 2'b01,
		ROLE_SOURCE = 2'b10,
		ROLE_NONE = 2'b11
	} tpc_role_t;
endpackage : tpc_pkg

// File: logic/tpc_port_regs.sv
// Purpose: I2C register bank steering a Type-C port detection engine
// Assumes: scl/sda and event inputs synchronous to ref_clk
// Notes: Open-drain pins pulled low while their enable is low
//
// Contract
// - Period field sets 60 to 90 ms cycle
// - Split field sets sink share, source remainder
// - Dangling cable bit enables its procedures
// - Pull-up field selects source current level
// - Global mask bit blocks interrupt pin
// - Remedy bit enables remedy detection
// - Threshold field selects 3.0 to 3.3 V
// - Weak supply forces sink when enabled and detection bit set
// - Debounce field sets 120 to 180 ms
// - Force commands make port source or sink
// - Command bits clear themselves except disable
// - Unattached commands move to unattached states
// - Recovery command enters error recovery
// - Disable bit holds port until cleared
// - Highest priority command wins, others dropped
// - Role write beats commands, waits for disable
// - Soft reset restores all registers
// - Mask bits keep flags off the pin
// - Masked events still set flags
// - Pin released when no unmasked flag
// - Flags readable, write one clears
// - Role priority dual, then sink, then source
// - Orientation flag only on resolve to CC
`include "tpc_cfg.svh"
module tpc_port_regs
	import tpc_pkg::*;
#(
	parameter int unsigned CYCLES_PER_MS = `TPC_CLK_MHZ * 1000
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// I2C pins
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOeB,
	// Interrupt pin
	output logic intOut,
	output logic intOeB,
	// Detection engine events and status
	input wire logic [5:0] eventIn,
	input wire logic [6:0] remedyEventIn,
	input wire logic [1:0] orientIn,
	input wire logic [3:0] vddBelow,
	// Port role register side
	input wire logic roleWrite,
	input wire logic [2:0] roleSelect,
	// Configuration to detection engine
	output logic [23:0] sinkCycles,
	output logic [23:0] sourceCycles,
	output logic [24:0] debounceCycles,
	output logic [1:0] pullupLevel,
	output logic danglingEnable,
	output logic remedyEnable,
	output logic detectEnable,
	output logic autoSinkActive,
	// Commands to detection engine
	output tpc_cmd_t portCmd,
	output logic cmdValid,
	output logic portDisabled,
	output tpc_role_t roleMode,
	output logic deviceReset
);
	localparam int unsigned RST_PERIOD = 70 * CYCLES_PER_MS;
	localparam int unsigned RST_SINK = RST_PERIOD * 60 / 100;
	localparam int unsigned RST_DEB = 150 * CYCLES_PER_MS;

	function automatic tpc_cmd_t pickCmd(input logic [7:0] d);
		if (d[`TPC_B_ERR]) pickCmd = CMD_RECOVER;
		else if (d[`TPC_B_FSRC]) pickCmd = CMD_FORCE_SOURCE_CMD;
		else if (d[`TPC_B_FSNK]) pickCmd = CMD_FORCE_SINK_CMD;
		else if (d[`TPC_B_USRC]) pickCmd = CMD_GOTO_UNATTACHED_SOURCE_CMD;
		else if (d[`TPC_B_USNK]) pickCmd = CMD_GOTO_UNATTACHED_SINK_CMD;
		else pickCmd = CMD_NONE;
	endfunction : pickCmd

	function automatic tpc_role_t pickRole(input logic [2:0] s);
		if (s[2]) pickRole = ROLE_DUAL;
		else if (s[1]) pickRole = ROLE_SINK;
		else if (s[0]) pickRole = ROLE_SOURCE;
		else pickRole = ROLE_NONE;
	endfunction : pickRole

	function automatic logic [31:0] msCycles(input logic [31:0] ms);
		msCycles = ms * CYCLES_PER_MS;
	endfunction : msCycles

	////////////////////////////////////////////////////////////////////////
	tpc_i2c_st_t state;
	logic sclQ, sdaQ, nack, readMode, wrStb, swReset, next_disabled;
	logic [3:0] bitCnt;
	logic [7:0] shiftIn, shiftOut, regAddr, wrAddr, wrData, rdByte;
	logic [7:0] ctl, ctl2, mask, mask2;
	logic [6:0] flags, flags2;
	logic [1:0] orientQ;
	logic [2:0] roleSel;
	logic rolePending;
	logic [31:0] periodMs, sinkPct;

	wire sclRise = sclIn & ~sclQ;
	wire sclFall = ~sclIn & sclQ;
	wire startCond = sclIn & sclQ & sdaQ & ~sdaIn;
	wire stopCond = sclIn & sclQ & ~sdaQ & sdaIn;
	wire wrCtl = wrStb && wrAddr == `TPC_OFF_CTL;
	wire wrCtl2 = wrStb && wrAddr == `TPC_OFF_CTL2;
	wire wrManual = wrStb && wrAddr == `TPC_OFF_MANUAL;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			sclQ <= 1'b1;
			sdaQ <= 1'b1;
		end else begin
			sclQ <= sclIn;
			sdaQ <= sdaIn;
		end
	end

	assign sdaOut = 1'b0;
	assign intOut = 1'b0;

	// Bus engine is not reset by soft reset so the ack completes
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= I2C_IDLE;
			bitCnt <= 4'h0;
			shiftIn <= 8'h00;
			shiftOut <= 8'hFF;
			regAddr <= 8'h00;
			readMode <= 1'b0;
			nack <= 1'b0;
			sdaOeB <= 1'b1;
			wrStb <= 1'b0;
			wrAddr <= 8'h00;
			wrData <= 8'h00;
		end else begin
			wrStb <= 1'b0;
			if (startCond) begin
				state <= I2C_ADDR;
				bitCnt <= 4'h0;
				sdaOeB <= 1'b1;
			end else if (stopCond) begin
				state <= I2C_IDLE;
				sdaOeB <= 1'b1;
			end else begin
				case (state)
				I2C_ADDR, I2C_REG, I2C_WDATA: begin
					if (sclRise) begin
						shiftIn <= {shiftIn[6:0], sdaIn};
						bitCnt <= 4'(bitCnt + 4'h1);
					end else if (sclFall && bitCnt == 4'h8) begin
						bitCnt <= 4'h0;
						sdaOeB <= 1'b0;
						if (state == I2C_ADDR) begin
							if (shiftIn[7:1] == `TPC_I2C_ADDR) begin
								readMode <= shiftIn[0];
								state <= I2C_AACK;
							end else begin
								sdaOeB <= 1'b1;
								state <= I2C_IDLE;
							end
						end else if (state == I2C_REG) begin
							regAddr <= shiftIn;
							state <= I2C_WACK;
						end else begin
							wrStb <= 1'b1;
							wrAddr <= regAddr;
							wrData <= shiftIn;
							regAddr <= 8'(regAddr + 8'h01);
							state <= I2C_WACK;
						end
					end
				end
				I2C_AACK, I2C_RACK: begin
					if (sclRise) begin
						nack <= sdaIn & (state == I2C_RACK);
					end else if (sclFall) begin
						if ((state == I2C_AACK && !readMode) || nack) begin
							sdaOeB <= 1'b1;
							state <= nack ? I2C_IDLE : I2C_REG;
						end else begin
							sdaOeB <= rdByte[7];
							shiftOut <= {rdByte[6:0], 1'b1};
							regAddr <= 8'(regAddr + 8'h01);
							bitCnt <= 4'h0;
							state <= I2C_RDATA;
						end
					end
				end
				I2C_WACK: begin
					if (sclFall) begin
						sdaOeB <= 1'b1;
						state <= I2C_WDATA;
					end
				end
				I2C_RDATA: begin
					if (sclRise) begin
						bitCnt <= 4'(bitCnt + 4'h1);
					end else if (sclFall) begin
						if (bitCnt == 4'h8) begin
							sdaOeB <= 1'b1;
							state <= I2C_RACK;
						end else begin
							sdaOeB <= shiftOut[7];
							shiftOut <= {shiftOut[6:0], 1'b1};
						end
					end
				end
				default: state <= I2C_IDLE;
				endcase
			end
		end
	end

	// Write-only and self-clearing bits read back as zero
	always_comb begin
		case (regAddr)
		`TPC_OFF_CTL: rdByte = ctl;
		`TPC_OFF_CTL2: rdByte = ctl2;
		`TPC_OFF_MANUAL: rdByte = {6'h00, portDisabled, 1'b0};
		`TPC_OFF_MASK: rdByte = mask;
		`TPC_OFF_MASK2: rdByte = mask2;
		`TPC_OFF_FLAGS: rdByte = {1'b0, flags};
		`TPC_OFF_FLAGS2: rdByte = {1'b0, flags2};
		default: rdByte = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			swReset <= 1'b0;
			deviceReset <= 1'b0;
		end else begin
			swReset <= wrStb && wrAddr == `TPC_OFF_SWRST &&
				wrData[`TPC_B_SWRST];
			deviceReset <= wrStb && wrAddr == `TPC_OFF_SWRST &&
				wrData[`TPC_B_SWRST];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctl <= `TPC_RST_CTL;
			ctl2 <= `TPC_RST_CTL2;
			mask <= `TPC_RST_MASK;
			mask2 <= `TPC_RST_MASK;
		end else if (swReset) begin
			ctl <= `TPC_RST_CTL;
			ctl2 <= `TPC_RST_CTL2;
			mask <= `TPC_RST_MASK;
			mask2 <= `TPC_RST_MASK;
		end else begin
			if (wrCtl) begin
				ctl <= wrData;
				if (wrData[`TPC_F_PULLUP] == `TPC_PULLUP_RSV)
					ctl[`TPC_F_PULLUP] <= ctl[`TPC_F_PULLUP];
			end
			if (wrCtl2) begin
				ctl2 <= wrData;
				if (wrData[`TPC_F_DEB] == `TPC_DEB_RSV)
					ctl2[`TPC_F_DEB] <= ctl2[`TPC_F_DEB];
			end
			if (wrStb && wrAddr == `TPC_OFF_MASK)
				mask <= wrData & `TPC_MASK_USED;
			if (wrStb && wrAddr == `TPC_OFF_MASK2)
				mask2 <= wrData & `TPC_MASK2_USED;
		end
	end

	always_comb begin
		periodMs = `TPC_PERIOD_BASE_MS +
			`TPC_PERIOD_STEP_MS * 32'(ctl[`TPC_F_PERIOD]);
		sinkPct = `TPC_SPLIT_BASE_PCT -
			`TPC_SPLIT_STEP_PCT * 32'(ctl[`TPC_F_SPLIT]);
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			sinkCycles <= 24'(RST_SINK);
			sourceCycles <= 24'(RST_PERIOD - RST_SINK);
			debounceCycles <= 25'(RST_DEB);
		end else begin
			sinkCycles <= 24'(msCycles(periodMs) * sinkPct / 100);
			sourceCycles <= 24'(msCycles(periodMs) -
				msCycles(periodMs) * sinkPct / 100);
			debounceCycles <= 25'(msCycles(`TPC_DEB_BASE_MS +
				`TPC_DEB_STEP_MS * 32'(ctl2[`TPC_F_DEB])));
		end
	end

	// Outputs are register fields, already flip-flops
	assign pullupLevel = ctl[`TPC_F_PULLUP];
	assign danglingEnable = ctl[`TPC_B_DANGLE];
	assign remedyEnable = ctl2[`TPC_B_REMEDY];
	assign detectEnable = ctl2[`TPC_B_DETEN];

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			autoSinkActive <= 1'b0;
		else
			autoSinkActive <= ctl2[`TPC_B_WEAKEN] & detectEnable &
				vddBelow[ctl2[`TPC_F_WEAKTH]];
	end

	////////////////////////////////////////////////////////////////////////
	assign next_disabled = wrManual ? wrData[`TPC_B_DIS] : portDisabled;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			portDisabled <= 1'b0;
			portCmd <= CMD_NONE;
			cmdValid <= 1'b0;
			roleMode <= ROLE_SINK;
			roleSel <= 3'h0;
			rolePending <= 1'b0;
		end else if (swReset) begin
			portDisabled <= 1'b0;
			portCmd <= CMD_NONE;
			cmdValid <= 1'b0;
			roleMode <= ROLE_SINK;
			rolePending <= 1'b0;
		end else begin
			portDisabled <= next_disabled;
			// Single-cycle pulse: the command bits never hold
			portCmd <= CMD_NONE;
			cmdValid <= 1'b0;
			if (wrManual && !next_disabled && !roleWrite && !rolePending &&
				pickCmd(wrData) != CMD_NONE) begin
				portCmd <= pickCmd(wrData);
				cmdValid <= 1'b1;
			end
			if (roleWrite) begin
				roleSel <= roleSelect;
				rolePending <= 1'b1;
			end
			// A held disable parks the new role until it is cleared
			if ((roleWrite || rolePending) && !next_disabled) begin
				roleMode <= pickRole(roleWrite ? roleSelect : roleSel);
				rolePending <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	wire flagClr = wrStb && wrAddr == `TPC_OFF_FLAGS;
	wire flagClr2 = wrStb && wrAddr == `TPC_OFF_FLAGS2;
	wire orientSet = orientQ == 2'b00 && (orientIn == 2'b01 ||
		orientIn == 2'b10);
	wire [6:0] setFlags = {orientSet, eventIn};
	wire [6:0] setFlags2 = remedyEventIn & 7'(`TPC_MASK2_USED);

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			orientQ <= 2'b00;
			flags <= 7'h00;
			flags2 <= 7'h00;
			intOeB <= 1'b1;
		end else begin
			orientQ <= orientIn;
			if (swReset) begin
				flags <= 7'h00;
				flags2 <= 7'h00;
			end else begin
				// Set wins over a same-cycle clear
				flags <= (flags & ~(flagClr ? wrData[6:0] : 7'h00)) |
					setFlags;
				flags2 <= (flags2 & ~(flagClr2 ? wrData[6:0] : 7'h00)) |
					setFlags2;
			end
			intOeB <= ctl[`TPC_B_GMASK] || ((flags & ~mask[6:0]) == 7'h00 &&
				(flags2 & ~mask2[6:0]) == 7'h00);
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	sequence s_cmdWrite;
		wrManual && wrData[`TPC_B_ERR] && wrData[`TPC_B_FSRC] &&
			!wrData[`TPC_B_DIS] && !roleWrite && !rolePending && !swReset;
	endsequence
	sequence s_cmdPulse;
		cmdValid && portCmd == CMD_RECOVER ##1 !cmdValid;
	endsequence

	property p_period;
		32'(sinkCycles) + 32'(sourceCycles) == msCycles(`TPC_PERIOD_BASE_MS +
			`TPC_PERIOD_STEP_MS * 32'($past(ctl[`TPC_F_PERIOD])));
	endproperty
	a_period: assert property (p_period) else $error("period wrong");
	property p_split;
		32'(sinkCycles) * 100 == (32'(sinkCycles) + 32'(sourceCycles)) *
			(`TPC_SPLIT_BASE_PCT - `TPC_SPLIT_STEP_PCT *
			32'($past(ctl[`TPC_F_SPLIT])));
	endproperty
	a_split: assert property (p_split) else $error("split wrong");
	property p_pullRsv;
		wrCtl && wrData[`TPC_F_PULLUP] == `TPC_PULLUP_RSV && !swReset
			|=> $stable(pullupLevel);
	endproperty
	a_pullRsv: assert property (p_pullRsv) else $error("pullup");
	property p_gmask;
		ctl[`TPC_B_GMASK] |=> intOeB;
	endproperty
	a_gmask: assert property (p_gmask) else $error("global mask");
	property p_deb;
		32'(debounceCycles) == msCycles(`TPC_DEB_BASE_MS +
			`TPC_DEB_STEP_MS * 32'($past(ctl2[`TPC_F_DEB])));
	endproperty
	a_deb: assert property (p_deb) else $error("debounce wrong");
	property p_prio;
		s_cmdWrite |=> s_cmdPulse;
	endproperty
	a_prio: assert property (p_prio) else $error("priority");
	property p_disHold;
		portDisabled && !wrManual && !swReset |=> portDisabled;
	endproperty
	a_disHold: assert property (p_disHold) else $error("disable");
	property p_roleWait;
		portDisabled |-> $stable(roleMode);
	endproperty
	a_roleWait: assert property (p_roleWait) else $error("role");
	property p_flagSet;
		eventIn[0] && !swReset |=> flags[0] ##1
			(flags[0] || $past(flagClr) || $past(swReset));
	endproperty
	a_flagSet: assert property (p_flagSet) else $error("flag lost");
	property p_release;
		(flags & ~mask[6:0]) == 7'h00 && (flags2 & ~mask2[6:0]) == 7'h00
			|=> intOeB;
	endproperty
	a_release: assert property (p_release) else $error("pin held");
	property p_orient;
		orientQ == 2'b00 && orientIn == 2'b11 && !flags[`TPC_B_ORIENT] &&
			!flagClr |=> !flags[`TPC_B_ORIENT];
	endproperty
	a_orient: assert property (p_orient) else $error("orient");
endmodule : tpc_port_regs

// File: dv/tpc_i2c_host.sv
// Purpose: I2C controller model standing in for the host processor
// Assumes: SDA pulled up outside, wires sampled on ref_clk
// Notes: Four-clock phases stay clear of the two-clock minimum
`include "tpc_cfg.svh"
module tpc_i2c_host (
	// Clock
	input wire logic ref_clk,
	// Bus wires
	input wire logic sdaLine,
	output logic sclOut,
	output logic sdaDrive
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PH = 4;
	initial begin
		sclOut = 1'b1;
		sdaDrive = 1'b1;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic waitClk(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : waitClk
	task automatic start();
		waitClk(1);
		sdaDrive = 1'b1;
		waitClk(PH);
		sclOut = 1'b1;
		waitClk(PH);
		sdaDrive = 1'b0;
		waitClk(PH);
		sclOut = 1'b0;
	endtask : start
	task automatic stop();
		waitClk(1);
		sdaDrive = 1'b0;
		waitClk(PH);
		sclOut = 1'b1;
		waitClk(PH);
		sdaDrive = 1'b1;
		waitClk(PH);
	endtask : stop
	// SDA moves one clock after SCL falls, never with it
	task automatic bitIo(input logic b, output logic r);
		waitClk(1);
		sdaDrive = b;
		waitClk(PH);
		sclOut = 1'b1;
		waitClk(PH);
		r = sdaLine;
		sclOut = 1'b0;
	endtask : bitIo
	// Ninth bit always released: ack slot on writes, NACK on reads
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx,
		output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitIo(tx[i], r);
			rx[i] = r;
		end
		bitIo(1'b1, r);
		ack = ~r;
	endtask : xfer
	////////////////////////////////////////////////////////////////////////
	task automatic wrReg(input logic [7:0] off, input logic [7:0] val,
		output logic ok);
		logic [7:0] rx;
		logic a0, a1, a2;
		start();
		xfer({`TPC_I2C_ADDR, 1'b0}, rx, a0);
		xfer(off, rx, a1);
		xfer(val, rx, a2);
		stop();
		ok = a0 & a1 & a2;
	endtask : wrReg
	task automatic rdReg(input logic [7:0] off, output logic [7:0] val,
		output logic ok);
		logic [7:0] rx;
		logic a0, a1, a2, a3;
		start();
		xfer({`TPC_I2C_ADDR, 1'b0}, rx, a0);
		xfer(off, rx, a1);
		stop();
		start();
		xfer({`TPC_I2C_ADDR, 1'b1}, rx, a2);
		xfer(8'hFF, val, a3);
		stop();
		ok = a0 & a1 & a2;
	endtask : rdReg
endmodule : tpc_i2c_host

// File: dv/typec_port_control_registers_bench.sv
// Purpose: Self-checking bench for the port control register bank
// Assumes: Host model on the I2C wires, ten clocks per millisecond
// Notes: Every compare goes through chk
`include "tpc_cfg.svh"
module typec_port_control_registers_bench import tpc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MS = 10;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [5:0] eventIn = 6'h00;
	logic [6:0] remedyEventIn = 7'h00;
	logic [1:0] orientIn = 2'h0;
	logic [3:0] vddBelow = 4'h0;
	logic roleWrite = 1'b0;
	logic [2:0] roleSelect = 3'h0;
	logic sclIn, sdaDrive, sdaOut, sdaOeB, intOut, intOeB;
	logic [23:0] sinkCycles, sourceCycles;
	logic [24:0] debounceCycles;
	logic [1:0] pullupLevel;
	logic danglingEnable, remedyEnable, detectEnable, autoSinkActive;
	logic cmdValid, portDisabled, deviceReset;
	tpc_cmd_t portCmd;
	tpc_role_t roleMode;
	wire logic sdaLine = sdaDrive & (sdaOeB | sdaOut);
	wire logic intLine = intOeB | intOut;
	int error_cnt = 0;
	int cmp_count = 0;
	int cmdCnt = 0;
	int rstCnt = 0;
	tpc_cmd_t lastCmd;
	////////////////////////////////////////////////////////////////////////
	tpc_port_regs #(.CYCLES_PER_MS(MS)) u_dut (.ref_clk, .rst_b, .sclIn,
		.sdaIn(sdaLine), .sdaOut, .sdaOeB, .intOut, .intOeB, .eventIn,
		.remedyEventIn, .orientIn, .vddBelow, .roleWrite, .roleSelect,
		.sinkCycles, .sourceCycles, .debounceCycles, .pullupLevel,
		.danglingEnable, .remedyEnable, .detectEnable, .autoSinkActive,
		.portCmd, .cmdValid, .portDisabled, .roleMode, .deviceReset);
	tpc_i2c_host u_host (.ref_clk, .sdaLine, .sclOut(sclIn), .sdaDrive);
	always #5 ref_clk = ~ref_clk;
	// Pulses last one cycle, so they are caught here
	always @(posedge ref_clk) begin
		if (cmdValid === 1'b1) begin
			cmdCnt++;
			lastCmd = portCmd;
		end
		if (deviceReset === 1'b1) rstCnt++;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick
	task automatic chk(input string what, input logic [24:0] exp,
		input logic [24:0] got);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] off, input logic [7:0] val);
		logic ok;
		u_host.wrReg(off, val, ok);
		chk("writeAck", 25'h1, 25'(ok));
	endtask : wr
	task automatic rdChk(input logic [7:0] off, input logic [7:0] exp);
		logic [7:0] v;
		logic ok;
		u_host.rdReg(off, v, ok);
		chk("readAck", 25'h1, 25'(ok));
		chk($sformatf("reg%0h", off), 25'(exp), 25'(v));
	endtask : rdChk
	task automatic timing(input int p, input int s);
		int per;
		int sink_role_select;
		per = (60 + 10 * p) * MS;
		sink_role_select = per * (60 - 10 * s) / 100;
		chk("sinkCycles", 25'(sink_role_select), 25'(sinkCycles));
		chk("sourceCycles", 25'(per - sink_role_select), 25'(sourceCycles));
	endtask : timing
	task automatic cmdCase(input logic [7:0] v, input tpc_cmd_t exp);
		int n;
		n = cmdCnt;
		wr(`TPC_OFF_MANUAL, v);
		chk("cmdPulses", 25'(n + 1), 25'(cmdCnt));
		chk("portCmd", 25'(exp), 25'(lastCmd));
	endtask : cmdCase
	task automatic rolePulse(input logic [2:0] sel);
		roleWrite = 1'b1;
		roleSelect = sel;
		tick(1);
		roleWrite = 1'b0;
		tick(2);
	endtask : rolePulse
	task automatic evPulse(input logic [5:0] ev, input logic [6:0] rem);
		eventIn = ev;
		remedyEventIn = rem;
		tick(1);
		eventIn = 6'h00;
		remedyEventIn = 7'h00;
		tick(3);
	endtask : evPulse
	////////////////////////////////////////////////////////////////////////
	task automatic resetCase();
		rdChk(`TPC_OFF_CTL, 8'h4B);
		rdChk(`TPC_OFF_CTL2, 8'hB3);
		rdChk(8'h07, 8'h00);
		timing(1, 0);
		chk("debounce", 25'(150 * MS), debounceCycles);
		chk("role", 25'(ROLE_SINK), 25'(roleMode));
	endtask : resetCase
	task automatic fieldCase();
		for (int p = 0; p < 4; p++) begin
			wr(`TPC_OFF_CTL, {2'(p), 2'(3 - p), 4'hF});
			timing(p, 3 - p);
			chk("dangle", 25'h1, 25'(danglingEnable));
			chk("pullup", 25'h3, 25'(pullupLevel));
		end
		wr(`TPC_OFF_CTL, 8'h09);
		chk("pullupKeep", 25'h3, 25'(pullupLevel));
		wr(`TPC_OFF_CTL, 8'h43);
		chk("pullup", 25'h1, 25'(pullupLevel));
		chk("dangle", 25'h0, 25'(danglingEnable));
		for (int d = 0; d < 7; d++) begin
			wr(`TPC_OFF_CTL2, {5'h11, 3'(d)});
			chk("debounce", 25'((120 + 10 * d) * MS), debounceCycles);
		end
		wr(`TPC_OFF_CTL2, 8'h8F);
		chk("debKeep", 25'(180 * MS), debounceCycles);
		chk("remedy", 25'h1, 25'(remedyEnable));
		chk("detect", 25'h1, 25'(detectEnable));
	endtask : fieldCase
	task automatic autoSinkCase();
		wr(`TPC_OFF_CTL2, 8'h58);
		vddBelow = 4'h4;
		tick(3);
		chk("autoSink", 25'h1, 25'(autoSinkActive));
		vddBelow = 4'hB;
		tick(3);
		chk("autoSink", 25'h0, 25'(autoSinkActive));
		wr(`TPC_OFF_CTL2, 8'h78);
		chk("autoSink", 25'h1, 25'(autoSinkActive));
		wr(`TPC_OFF_CTL2, 8'h70);
		chk("autoSink", 25'h0, 25'(autoSinkActive));
		chk("detect", 25'h0, 25'(detectEnable));
		vddBelow = 4'hF;
		wr(`TPC_OFF_CTL2, 8'h48);
		chk("autoSink", 25'h0, 25'(autoSinkActive));
		chk("remedy", 25'h0, 25'(remedyEnable));
	endtask : autoSinkCase
	task automatic cmdsCase();
		int n;
		cmdCase(8'h20, CMD_FORCE_SOURCE_CMD);
		cmdCase(8'h10, CMD_FORCE_SINK_CMD);
		cmdCase(8'h04, CMD_GOTO_UNATTACHED_SOURCE_CMD);
		cmdCase(8'h08, CMD_GOTO_UNATTACHED_SINK_CMD);
		cmdCase(8'h01, CMD_RECOVER);
		cmdCase(8'h3D, CMD_RECOVER);
		cmdCase(8'h3C, CMD_FORCE_SOURCE_CMD);
		cmdCase(8'h0C, CMD_GOTO_UNATTACHED_SOURCE_CMD);
		rdChk(`TPC_OFF_MANUAL, 8'h00);
		n = cmdCnt;
		wr(`TPC_OFF_MANUAL, 8'h23);
		chk("cmdPulses", 25'(n), 25'(cmdCnt));
		chk("disabled", 25'h1, 25'(portDisabled));
		rdChk(`TPC_OFF_MANUAL, 8'h02);
		rolePulse(3'h7);
		chk("roleHeld", 25'(ROLE_SINK), 25'(roleMode));
		wr(`TPC_OFF_MANUAL, 8'h00);
		chk("disabled", 25'h0, 25'(portDisabled));
		chk("role", 25'(ROLE_DUAL), 25'(roleMode));
		rolePulse(3'h3);
		chk("role", 25'(ROLE_SINK), 25'(roleMode));
		rolePulse(3'h1);
		chk("role", 25'(ROLE_SOURCE), 25'(roleMode));
	endtask : cmdsCase
	task automatic irqCase();
		wr(`TPC_OFF_CTL, 8'h4C);
		chk("pullup", 25'h2, 25'(pullupLevel));
		chk("intPin", 25'h1, 25'(intLine));
		evPulse(6'h01, 7'h00);
		chk("intPin", 25'h0, 25'(intLine));
		wr(`TPC_OFF_MASK, 8'h01);
		chk("intPin", 25'h1, 25'(intLine));
		rdChk(`TPC_OFF_FLAGS, 8'h01);
		wr(`TPC_OFF_MASK, 8'h00);
		chk("intPin", 25'h0, 25'(intLine));
		wr(`TPC_OFF_CTL, 8'h4B);
		chk("intPin", 25'h1, 25'(intLine));
		wr(`TPC_OFF_FLAGS, 8'h01);
		rdChk(`TPC_OFF_FLAGS, 8'h00);
		orientIn = 2'h3;
		tick(2);
		orientIn = 2'h0;
		tick(2);
		rdChk(`TPC_OFF_FLAGS, 8'h00);
		orientIn = 2'h1;
		evPulse(6'h3E, 7'h01);
		rdChk(`TPC_OFF_FLAGS, 8'h7E);
		rdChk(`TPC_OFF_FLAGS2, 8'h01);
		wr(`TPC_OFF_MASK2, 8'hFF);
		rdChk(`TPC_OFF_MASK2, 8'h6F);
		// Zero bits of a clear write must leave their flags alone
		wr(`TPC_OFF_FLAGS, 8'h3F);
		rdChk(`TPC_OFF_FLAGS, 8'h40);
		wr(`TPC_OFF_FLAGS, 8'h40);
		wr(`TPC_OFF_CTL, 8'h4A);
		chk("intPin", 25'h1, 25'(intLine));
		wr(`TPC_OFF_MASK2, 8'h6E);
		chk("intPin", 25'h0, 25'(intLine));
	endtask : irqCase
	task automatic softResetCase();
		int n;
		n = rstCnt;
		wr(`TPC_OFF_SWRST, 8'h01);
		chk("resetPulse", 25'(n + 1), 25'(rstCnt));
		rdChk(`TPC_OFF_CTL, 8'h4B);
		rdChk(`TPC_OFF_MASK2, 8'h00);
		rdChk(`TPC_OFF_FLAGS2, 8'h00);
		chk("intPin", 25'h1, 25'(intLine));
		chk("role", 25'(ROLE_SINK), 25'(roleMode));
	endtask : softResetCase
	////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("Compares %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : print_verdict
	initial begin
		tick(16);
		rst_b = 1'b1;
		tick(2);
		resetCase();
		fieldCase();
		autoSinkCase();
		cmdsCase();
		irqCase();
		softResetCase();
		print_verdict();
	end
	// Hang guard
	initial begin
		repeat (100000) @(posedge ref_clk);
		error_cnt++;
		$display("[FAIL] watchdog expected done seen hang");
		print_verdict();
	end
endmodule : typec_port_control_registers_bench
